// ==== verilog/plic_consts.svh ====
`ifndef PLIC_CONSTS_SVH
`define PLIC_CONSTS_SVH

// pclk half period in clk_sys cycles
`define PLIC_HALF_NEW   3'h2
`define PLIC_HALF_OLD   3'h4
// phy to link control codes
`define PLIC_CTL_IDLE   2'h0
`define PLIC_CTL_STATUS 2'h1
`define PLIC_CTL_GRANT  2'h3
// fastest speed code kept in legacy mode
`define PLIC_SPD_S400   3'h4
// last body bit index, stop bit included
`define PLIC_LAST_BUS   4'h3
`define PLIC_LAST_READ  4'h4
`define PLIC_LAST_WRITE 4'hC
`define PLIC_LAST_ACC   4'h1
// register holding the feature enables
`define PLIC_REG_FEAT   4'h5
`define PLIC_BIT_ACCEL  1
`define PLIC_BIT_CONCAT 0
// serial frame lengths on the request line
`define PLIC_LEN_SHORT  5'h07
`define PLIC_LEN_LONG   5'h08
`define PLIC_LEN_READ   5'h09
`define PLIC_LEN_WRITE  5'h11
`define PLIC_LEN_ACC    5'h06

`endif

// ==== verilog/plic_pkg.sv ====
package plic_pkg;

	typedef enum logic [2:0]
	{
		PLIC_REQ_IMM   = 3'b000,
		PLIC_REQ_ISO   = 3'b001,
		PLIC_REQ_PRI   = 3'b010,
		PLIC_REQ_FAIR  = 3'b011,
		PLIC_REQ_READ  = 3'b100,
		PLIC_REQ_WRITE = 3'b101,
		PLIC_REQ_ACC   = 3'b110,
		PLIC_REQ_RSV   = 3'b111
	} plic_req_t;

	typedef enum logic [1:0]
	{
		PLIC_P_IDLE = 2'b00,
		PLIC_P_TYPE = 2'b01,
		PLIC_P_BODY = 2'b10
	} plic_pstate_t;

	typedef enum logic [1:0]
	{
		PLIC_SYM_IDLE   = 2'b00,
		PLIC_SYM_PREFIX = 2'b01,
		PLIC_SYM_END    = 2'b10
	} plic_sym_t;

endpackage : plic_pkg

// ==== verilog/plic_if.sv ====
`timescale 1ns/1ps
interface plic_if;
	logic       pclk;
	logic       link_request_line;
	logic [1:0] ctl;
	logic [7:0] d;
	logic       phy_interrupt_output;
	logic       link_clock_power_mgmt_input;

	modport phy
	(
		output pclk,
		output ctl,
		output d,
		output phy_interrupt_output,
		input  link_request_line,
		input  link_clock_power_mgmt_input
	);

	modport link
	(
		input  pclk,
		input  ctl,
		input  d,
		input  phy_interrupt_output,
		output link_request_line,
		output link_clock_power_mgmt_input
	);
endinterface : plic_if

// ==== verilog/plic_phy.sv ====
`timescale 1ns/1ps
`include "plic_consts.svh"

// What the phy and link blocks do
// R1: strap high selects newer link interface
// R2: strap low selects legacy link interface
// R3: no annex isolation support in legacy
// R4: link may leave interrupt output open
// R5: link grounds power-management clock input
// R6: no accel request means accel bit cleared
// R7: no multispeed support means concat bit cleared
// R8: decode short and long bus requests
// R9: short request then another, both decoded
// R10: speed codes up to S400 stay compatible
// R11: legacy over-S400 request sends null packet
// R12: reset held two ms after power; rst_n comes from outside, the testbench holds it low eight clk_sys cycles
// R13: pclk rate halves in legacy mode
// R14: all clocks derived from one reference
// R15: launch and sample on pclk rise
// R16: link sends requests serially on request line
// R17: strap sampled once at reset release
module plic_phy
	import plic_pkg::*;
(
	// system
	input  wire logic  clk_sys,
	input  wire logic  rst_n,
	// strap
	input  wire logic  interface_generation_strap,
	// status
	output logic       mode_newer,
	output logic       power_management_clock_mode,
	output logic       accel_arbitration_enable,
	output logic       multispeed_concat_enable,
	// decoded bus requests
	output logic       req_valid,
	output logic [2:0] req_type,
	output logic [2:0] req_speed,
	output plic_sym_t  ser_sym,
	// link side
	plic_if.phy        lnk
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [3:0] body_last(input logic [2:0] t);
		case (t)
			PLIC_REQ_READ:  body_last = `PLIC_LAST_READ;
			PLIC_REQ_WRITE: body_last = `PLIC_LAST_WRITE;
			PLIC_REQ_ACC:   body_last = `PLIC_LAST_ACC;
			PLIC_REQ_RSV:   body_last = `PLIC_LAST_ACC;
			default:        body_last = `PLIC_LAST_BUS;
		endcase
	endfunction : body_last

	// ****************************************
	// strap and pin synchronisers
	// ****************************************
	logic       strap_s1_r;
	logic       strap_s2_r;
	logic       rqln_s1_r;
	logic       rqln_s2_r;
	logic       pmgt_s1_r;
	logic       pmgt_s2_r;
	logic [1:0] lock_cnt_r;
	logic       locked_r;
	logic       mode_r;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strap_s1_r <= 1'b0;
			strap_s2_r <= 1'b0;
			rqln_s1_r  <= 1'b0;
			rqln_s2_r  <= 1'b0;
			pmgt_s1_r  <= 1'b0;
			pmgt_s2_r  <= 1'b0;
		end
		else
		begin
			strap_s1_r <= interface_generation_strap;
			strap_s2_r <= strap_s1_r;
			rqln_s1_r  <= lnk.link_request_line;
			rqln_s2_r  <= rqln_s1_r;
			pmgt_s1_r  <= lnk.link_clock_power_mgmt_input;
			pmgt_s2_r  <= pmgt_s1_r;
		end
	end

	// mode fixed once, on the third edge after release, never changed later
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lock_cnt_r <= 2'h0;
			locked_r   <= 1'b0;
			mode_r     <= 1'b0;
		end
		else if (!locked_r)
		begin
			lock_cnt_r <= lock_cnt_r + 2'h1;
			if (lock_cnt_r == 2'h2)
			begin
				locked_r <= 1'b1;
				mode_r   <= strap_s2_r; // R1 R2 R17
			end
		end
	end

	// ****************************************
	// interface clock divider
	// ****************************************
	logic [2:0] div_cnt_r;
	logic       pclk_r;
	logic [2:0] half_w;
	logic       rise_w;

	assign half_w = mode_r ? `PLIC_HALF_NEW : `PLIC_HALF_OLD; // R13
	assign rise_w = locked_r && (div_cnt_r == half_w - 3'h1) && !pclk_r;

	// one reference clock feeds pclk and all link timing
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_cnt_r <= 3'h0;
			pclk_r    <= 1'b0;
		end
		else if (locked_r)
		begin
			if (div_cnt_r == half_w - 3'h1)
			begin
				div_cnt_r <= 3'h0;
				pclk_r    <= ~pclk_r; // R14
			end
			else
			begin
				div_cnt_r <= div_cnt_r + 3'h1;
			end
		end
	end

	// ****************************************
	// request line parser
	// ****************************************
	plic_pstate_t st_r;
	logic [2:0]   typ_r;
	logic [3:0]   cnt_r;
	logic [11:0]  sh_r;
	logic         bit_w;
	logic         is_bus_w;
	logic         fin_w;
	logic         fin_bus_w;
	logic         fin_rd_w;
	logic         fin_wr_w;
	logic         fin_acc_w;
	logic         chain_w;
	logic         null_w;

	assign bit_w    = rqln_s2_r;
	assign is_bus_w = !typ_r[2];
	// stop bit reached, sampled on pclk rise
	assign fin_w    = rise_w && (st_r == PLIC_P_BODY) && (cnt_r == body_last(typ_r)); // R15
	assign fin_bus_w = fin_w && is_bus_w; // R8
	assign fin_rd_w  = fin_w && (typ_r == PLIC_REQ_READ);
	assign fin_wr_w  = fin_w && (typ_r == PLIC_REQ_WRITE);
	assign fin_acc_w = fin_w && (typ_r == PLIC_REQ_ACC);
	// short form: bit six was the stop, a one now is the next start
	assign chain_w  = fin_bus_w && !sh_r[0] && bit_w; // R9
	// top two speed bits equal the short code up to S400
	assign null_w   = fin_bus_w && !mode_r && (sh_r[2:0] > `PLIC_SPD_S400); // R10 R11

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r  <= PLIC_P_IDLE;
			typ_r <= 3'h0;
			cnt_r <= 4'h0;
			sh_r  <= 12'h000;
		end
		else if (rise_w)
		begin
			case (st_r)
				PLIC_P_IDLE:
				begin
					cnt_r <= 4'h0;
					if (bit_w)
					begin
						st_r <= PLIC_P_TYPE;
					end
				end
				PLIC_P_TYPE:
				begin
					typ_r <= {typ_r[1:0], bit_w};
					cnt_r <= cnt_r + 4'h1;
					if (cnt_r == 4'h2)
					begin
						st_r  <= PLIC_P_BODY;
						cnt_r <= 4'h0;
					end
				end
				PLIC_P_BODY:
				begin
					sh_r  <= {sh_r[10:0], bit_w};
					cnt_r <= cnt_r + 4'h1;
					if (chain_w)
					begin
						st_r  <= PLIC_P_TYPE; // R9
						cnt_r <= 4'h0;
					end
					else if (fin_w)
					begin
						st_r <= PLIC_P_IDLE;
					end
				end
				default:
				begin
					st_r <= PLIC_P_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] regs_r [16];
	logic       acc_on_r;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 16; i++)
			begin
				regs_r[i] <= 8'h00;
			end
		end
		else if (fin_wr_w)
		begin
			regs_r[sh_r[11:8]] <= sh_r[7:0];
		end
	end

	// temporary accel on/off from the link
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_on_r <= 1'b1;
		end
		else if (fin_acc_w)
		begin
			acc_on_r <= sh_r[0];
		end
	end

	// ****************************************
	// status outputs
	// ****************************************
	logic       accel_r;
	logic       concat_r;
	logic       req_valid_r;
	logic [2:0] req_type_r;
	logic [2:0] req_speed_r;
	plic_sym_t  sym_r;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			accel_r  <= 1'b0;
			concat_r <= 1'b0;
		end
		else
		begin
			accel_r  <= regs_r[`PLIC_REG_FEAT][`PLIC_BIT_ACCEL] && acc_on_r; // R6
			concat_r <= regs_r[`PLIC_REG_FEAT][`PLIC_BIT_CONCAT]; // R7
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_valid_r <= 1'b0;
			req_type_r  <= 3'h0;
			req_speed_r <= 3'h0;
		end
		else
		begin
			req_valid_r <= fin_bus_w && !null_w;
			if (fin_bus_w)
			begin
				req_type_r  <= typ_r;
				req_speed_r <= sh_r[2:0]; // R8
			end
		end
	end

	// null packet: prefix then end, no payload
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sym_r <= PLIC_SYM_IDLE;
		end
		else if (null_w)
		begin
			sym_r <= PLIC_SYM_PREFIX; // R11
		end
		else if (sym_r == PLIC_SYM_PREFIX)
		begin
			sym_r <= PLIC_SYM_END; // R11
		end
		else
		begin
			sym_r <= PLIC_SYM_IDLE;
		end
	end

	// ****************************************
	// link side drivers
	// ****************************************
	logic [1:0] ctl_r;
	logic [7:0] d_r;
	logic       stat_pend_r;
	logic [7:0] stat_data_r;
	logic       int_r;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctl_r       <= `PLIC_CTL_IDLE;
			d_r         <= 8'h00;
			stat_pend_r <= 1'b0;
			stat_data_r <= 8'h00;
		end
		else if (rise_w)
		begin
			if (fin_bus_w && !null_w)
			begin
				ctl_r <= `PLIC_CTL_GRANT; // R15
				d_r   <= 8'h00;
			end
			else if (fin_rd_w)
			begin
				ctl_r       <= `PLIC_CTL_STATUS;
				d_r         <= {4'h0, sh_r[3:0]};
				stat_pend_r <= 1'b1;
				stat_data_r <= regs_r[sh_r[3:0]];
			end
			else if (stat_pend_r)
			begin
				ctl_r       <= `PLIC_CTL_STATUS;
				d_r         <= stat_data_r;
				stat_pend_r <= 1'b0;
			end
			else
			begin
				ctl_r <= `PLIC_CTL_IDLE;
				d_r   <= 8'h00;
			end
		end
	end

	// interrupt only in newer mode; legacy leaves it low
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			int_r <= 1'b0;
		end
		else
		begin
			int_r <= mode_r && fin_wr_w; // R4
		end
	end

	// launch one clk_sys after the pclk rise so the link samples a settled value
	logic [1:0] ctl_o_r;
	logic [7:0] d_o_r;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctl_o_r <= `PLIC_CTL_IDLE;
			d_o_r   <= 8'h00;
		end
		else
		begin
			ctl_o_r <= ctl_r; // R15
			d_o_r   <= d_r;
		end
	end

	assign lnk.pclk                 = pclk_r;
	assign lnk.ctl                  = ctl_o_r; // R3
	assign lnk.d                    = d_o_r;
	assign lnk.phy_interrupt_output = int_r;
	assign mode_newer               = mode_r;
	assign power_management_clock_mode = pmgt_s2_r;
	assign accel_arbitration_enable = accel_r;
	assign multispeed_concat_enable = concat_r;
	assign req_valid                = req_valid_r;
	assign req_type                 = req_type_r;
	assign req_speed                = req_speed_r;
	assign ser_sym                  = sym_r;

endmodule : plic_phy

// ==== verilog/plic_link.sv ====
`timescale 1ns/1ps
`include "plic_consts.svh"

module plic_link
	import plic_pkg::*;
#(
	parameter bit HAS_ACCEL_REQ = 1'b1,
	parameter bit HAS_MSPEED    = 1'b1
)
(
	// system
	input  wire logic  clk_sys,
	input  wire logic  rst_n,
	// command
	input  wire logic  cmd_valid,
	output logic       cmd_ready,
	input  wire logic [2:0] cmd_type,
	input  wire logic [2:0] cmd_speed,
	input  wire logic  cmd_short,
	input  wire logic [3:0] cmd_addr,
	input  wire logic [7:0] cmd_data,
	// answers
	output logic       rd_valid,
	output logic [3:0] rd_addr,
	output logic [7:0] rd_data,
	output logic       grant_seen,
	// phy side
	plic_if.link       lnk
);

	// ****************************************
	// frame builder
	// ****************************************
	logic [16:0] frm_w;
	logic [4:0]  len_w;
	logic [7:0]  wdat_w;

	always_comb
	begin
		wdat_w = cmd_data;
		if (cmd_addr == `PLIC_REG_FEAT)
		begin
			if (!HAS_ACCEL_REQ)
			begin
				wdat_w[`PLIC_BIT_ACCEL] = 1'b0; // R6
			end
			if (!HAS_MSPEED)
			begin
				wdat_w[`PLIC_BIT_CONCAT] = 1'b0; // R7
			end
		end
		case (cmd_type)
			PLIC_REQ_READ:
			begin
				frm_w = {1'b1, cmd_type, cmd_addr, 9'h000};
				len_w = `PLIC_LEN_READ;
			end
			PLIC_REQ_WRITE:
			begin
				frm_w = {1'b1, cmd_type, cmd_addr, wdat_w, 1'b0};
				len_w = `PLIC_LEN_WRITE;
			end
			PLIC_REQ_ACC:
			begin
				frm_w = {1'b1, cmd_type, cmd_data[0] & HAS_ACCEL_REQ, 12'h000};
				len_w = `PLIC_LEN_ACC;
			end
			default:
			begin
				frm_w = cmd_short ? {1'b1, cmd_type, cmd_speed[2:1], 11'h000}
				                  : {1'b1, cmd_type, cmd_speed, 10'h000};
				len_w = cmd_short ? `PLIC_LEN_SHORT : `PLIC_LEN_LONG;
			end
		endcase
	end

	// ****************************************
	// system side handshake
	// ****************************************
	logic [16:0] frm_r;
	logic [4:0]  len_r;
	logic        busy_r;
	logic        req_tog_r;
	logic        ack_s1_r;
	logic        ack_s2_r;
	logic        ack_seen_r;
	logic        ack_tog_r;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			frm_r      <= 17'h00000;
			len_r      <= 5'h00;
			busy_r     <= 1'b0;
			req_tog_r  <= 1'b0;
			ack_s1_r   <= 1'b0;
			ack_s2_r   <= 1'b0;
			ack_seen_r <= 1'b0;
		end
		else
		begin
			ack_s1_r <= ack_tog_r;
			ack_s2_r <= ack_s1_r;
			if (!busy_r && cmd_valid)
			begin
				frm_r     <= frm_w;
				len_r     <= len_w;
				busy_r    <= 1'b1;
				req_tog_r <= ~req_tog_r;
			end
			else if (busy_r && (ack_s2_r != ack_seen_r))
			begin
				ack_seen_r <= ack_s2_r;
				busy_r     <= 1'b0;
			end
		end
	end

	// ****************************************
	// request line shifter, pclk domain
	// ****************************************
	logic        rq_s1_r;
	logic        rq_s2_r;
	logic        rq_seen_r;
	logic [16:0] sh_r;
	logic [4:0]  left_r;
	logic        short_r;
	logic        rqln_r;
	logic        pmgt_r;
	logic        load_w;

	// after a short request the next start bit may follow its stop bit at once
	assign load_w = (rq_s2_r != rq_seen_r) && ((left_r == 5'h00) || (left_r == 5'h01 && short_r)); // R9

	always_ff @(posedge lnk.pclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rq_s1_r   <= 1'b0;
			rq_s2_r   <= 1'b0;
			rq_seen_r <= 1'b0;
			sh_r      <= 17'h00000;
			left_r    <= 5'h00;
			short_r   <= 1'b0;
			rqln_r    <= 1'b0;
			ack_tog_r <= 1'b0;
			pmgt_r    <= 1'b0;
		end
		else
		begin
			rq_s1_r <= req_tog_r;
			rq_s2_r <= rq_s1_r;
			pmgt_r  <= 1'b0; // R5
			rqln_r  <= (left_r != 5'h00) ? sh_r[16] : 1'b0; // R16
			if (load_w)
			begin
				rq_seen_r <= rq_s2_r;
				sh_r      <= frm_r;
				left_r    <= len_r;
				short_r   <= (len_r == `PLIC_LEN_SHORT);
				ack_tog_r <= ~ack_tog_r;
			end
			else if (left_r != 5'h00)
			begin
				sh_r   <= {sh_r[15:0], 1'b0};
				left_r <= left_r - 5'h01;
			end
		end
	end

	// ****************************************
	// status and grant capture, pclk domain
	// ****************************************
	logic       half_r;
	logic [3:0] st_addr_r;
	logic [7:0] st_data_r;
	logic       rd_tog_r;
	logic       gr_tog_r;

	always_ff @(posedge lnk.pclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			half_r    <= 1'b0;
			st_addr_r <= 4'h0;
			st_data_r <= 8'h00;
			rd_tog_r  <= 1'b0;
			gr_tog_r  <= 1'b0;
		end
		else if (lnk.ctl == `PLIC_CTL_STATUS)
		begin
			half_r <= ~half_r;
			if (!half_r)
			begin
				st_addr_r <= lnk.d[3:0];
			end
			else
			begin
				st_data_r <= lnk.d;
				rd_tog_r  <= ~rd_tog_r;
			end
		end
		else if (lnk.ctl == `PLIC_CTL_GRANT)
		begin
			gr_tog_r <= ~gr_tog_r;
		end
	end

	// ****************************************
	// answers back to clk_sys
	// ****************************************
	logic [2:0] rd_sy_r;
	logic [2:0] gr_sy_r;
	logic       rd_valid_r;
	logic       grant_r;
	logic [3:0] rd_addr_r;
	logic [7:0] rd_data_r;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_sy_r    <= 3'h0;
			gr_sy_r    <= 3'h0;
			rd_valid_r <= 1'b0;
			grant_r    <= 1'b0;
			rd_addr_r  <= 4'h0;
			rd_data_r  <= 8'h00;
		end
		else
		begin
			rd_sy_r    <= {rd_sy_r[1:0], rd_tog_r};
			gr_sy_r    <= {gr_sy_r[1:0], gr_tog_r};
			rd_valid_r <= rd_sy_r[2] != rd_sy_r[1];
			grant_r    <= gr_sy_r[2] != gr_sy_r[1];
			if (rd_sy_r[2] != rd_sy_r[1])
			begin
				rd_addr_r <= st_addr_r;
				rd_data_r <= st_data_r;
			end
		end
	end

	assign cmd_ready  = !busy_r;
	assign rd_valid   = rd_valid_r;
	assign rd_addr    = rd_addr_r;
	assign rd_data    = rd_data_r;
	assign grant_seen = grant_r;
	assign lnk.link_request_line           = rqln_r;
	assign lnk.link_clock_power_mgmt_input = pmgt_r;

endmodule : plic_link

// ==== testbench/plic_asserts.sv ====
`timescale 1ns/1ps
`include "plic_consts.svh"

module plic_asserts
(
	// system
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// link interface
	input  wire logic       pclk,
	input  wire logic       link_request_line,
	input  wire logic [1:0] ctl,
	input  wire logic [7:0] d,
	input  wire logic       phy_interrupt_output,
	input  wire logic       link_clock_power_mgmt_input
);
	// ****************************************
	// pclk half period tracking
	// ****************************************
	logic       pclk_q_r;
	logic [3:0] cnt_r;
	logic [3:0] half_r;
	logic [1:0] tog_r;
	logic       toggle;

	assign toggle = pclk != pclk_q_r;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pclk_q_r <= 1'b0;
			cnt_r    <= 4'h0;
			half_r   <= 4'h0;
			tog_r    <= 2'h0;
		end
		else
		begin
			pclk_q_r <= pclk;
			cnt_r    <= toggle ? 4'h1 : (cnt_r == 4'hF ? cnt_r : cnt_r + 4'h1);
			half_r   <= toggle ? cnt_r : half_r;
			tog_r    <= (toggle && tog_r != 2'h3) ? tog_r + 2'h1 : tog_r;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	a_pmgt_grounded: assert property (@(posedge clk_sys) disable iff (!rst_n)
		link_clock_power_mgmt_input == 1'b0) else $error("power management input not low");
	a_half_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
		toggle && tog_r != 2'h0 |-> cnt_r == {1'b0, `PLIC_HALF_NEW} || cnt_r == {1'b0, `PLIC_HALF_OLD})
		else $error("pclk half period wrong");
	a_mode_fixed: assert property (@(posedge clk_sys) disable iff (!rst_n)
		toggle && tog_r[1] |-> cnt_r == half_r) else $error("pclk rate changed in operation");
	a_int_legacy: assert property (@(posedge clk_sys) disable iff (!rst_n)
		tog_r[1] && half_r == {1'b0, `PLIC_HALF_OLD} |-> !phy_interrupt_output)
		else $error("interrupt raised in legacy mode");
	a_int_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
		phy_interrupt_output |=> !phy_interrupt_output) else $error("interrupt longer than one cycle");
	a_ctl_code: assert property (@(posedge pclk) disable iff (!rst_n)
		ctl != 2'h2) else $error("undefined control code");
	a_status_pair: assert property (@(posedge pclk) disable iff (!rst_n)
		ctl == `PLIC_CTL_STATUS && $past(ctl) != `PLIC_CTL_STATUS |=>
		ctl == `PLIC_CTL_STATUS ##1 ctl != `PLIC_CTL_STATUS) else $error("status not two periods");
	a_status_addr: assert property (@(posedge pclk) disable iff (!rst_n)
		ctl == `PLIC_CTL_STATUS && $past(ctl) != `PLIC_CTL_STATUS |-> d[7:4] == 4'h0)
		else $error("status address period bad");
	a_grant_one: assert property (@(posedge pclk) disable iff (!rst_n)
		ctl == `PLIC_CTL_GRANT |=> ctl != `PLIC_CTL_GRANT) else $error("grant longer than one period");

	c_grant: cover property (@(posedge pclk) ctl == `PLIC_CTL_GRANT);
	c_status: cover property (@(posedge pclk) ctl == `PLIC_CTL_STATUS);
	c_int: cover property (@(posedge clk_sys) phy_interrupt_output);
	c_reqline: cover property (@(posedge pclk) $rose(link_request_line));
endmodule : plic_asserts

// ==== testbench/phy_link_interface_mode_compat_test.sv ====
`timescale 1ns/1ps
`include "plic_consts.svh"

module phy_link_interface_mode_compat_test
	import plic_pkg::*;
;
	typedef struct packed {logic [1:0] k; logic [7:0] a; logic [7:0] b;} plic_note_t;
	logic       clk_sys, rst_n, interface_generation_strap, newer_exp, was_prefix;
	logic       mode_newer, power_management_clock_mode, accel_arbitration_enable, multispeed_concat_enable;
	logic       req_valid, cmd_valid, cmd_ready, cmd_short, rd_valid, grant_seen;
	logic [2:0] req_type, req_speed, cmd_type, cmd_speed;
	logic [3:0] cmd_addr, rd_addr;
	logic [7:0] cmd_data, rd_data;
	plic_sym_t  ser_sym;
	plic_note_t exp_q[$];
	logic [7:0] mem[16];
	int         n_errors, n_checks;

	plic_if lnk_if ();
	plic_phy plic_phy_inst (.clk_sys(clk_sys), .rst_n(rst_n), .interface_generation_strap(interface_generation_strap),
		.mode_newer(mode_newer), .power_management_clock_mode(power_management_clock_mode),
		.accel_arbitration_enable(accel_arbitration_enable), .multispeed_concat_enable(multispeed_concat_enable),
		.req_valid(req_valid), .req_type(req_type), .req_speed(req_speed), .ser_sym(ser_sym), .lnk(lnk_if.phy));
	plic_link plic_link_inst (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_type(cmd_type), .cmd_speed(cmd_speed), .cmd_short(cmd_short), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.rd_valid(rd_valid), .rd_addr(rd_addr), .rd_data(rd_data), .grant_seen(grant_seen), .lnk(lnk_if.link));
	plic_asserts plic_asserts_inst (.clk_sys(clk_sys), .rst_n(rst_n), .pclk(lnk_if.pclk),
		.link_request_line(lnk_if.link_request_line), .ctl(lnk_if.ctl), .d(lnk_if.d),
		.phy_interrupt_output(lnk_if.phy_interrupt_output),
		.link_clock_power_mgmt_input(lnk_if.link_clock_power_mgmt_input));

	// ****************************************
	// checking
	// ****************************************
	task automatic wrap_up();
		if (n_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask : chk

	task automatic take(input logic [1:0] k, input logic [7:0] a, input logic [7:0] b);
		plic_note_t n;
		if (exp_q.size() == 0)
		begin
			$display("wrong value result kind expected none seen %h", k);
			n_errors++;
		end
		else
		begin
			n = exp_q.pop_front();
			chk("result kind", {6'h0, n.k}, {6'h0, k});
			chk("result first", n.a, a);
			chk("result second", n.b, b);
		end
	endtask : take

	// results are taken mid-cycle, once settled
	always @(negedge clk_sys)
	begin
		if (rst_n)
		begin
			if (was_prefix)
				chk("null end", {6'h0, PLIC_SYM_END}, {6'h0, ser_sym});
			was_prefix = (ser_sym === PLIC_SYM_PREFIX);
			if (req_valid === 1'b1)
				take(2'h0, {5'h0, req_type}, {5'h0, req_speed});
			if (grant_seen === 1'b1)
				take(2'h3, 8'h00, 8'h00);
			if (rd_valid === 1'b1)
				take(2'h1, {4'h0, rd_addr}, rd_data);
			if (was_prefix)
				take(2'h2, 8'h00, 8'h00);
		end
	end

	// ****************************************
	// stimulus
	// ****************************************
	function automatic logic flag(input int sel);
		case (sel)
			0: return mode_newer;
			1: return accel_arbitration_enable;
			2: return multispeed_concat_enable;
			default: return power_management_clock_mode;
		endcase
	endfunction : flag

	task automatic chk_flag(input string what, input int sel, input logic exp);
		int i;
		for (i = 0; i < 400 && flag(sel) !== exp; i++)
			@(negedge clk_sys);
		chk(what, {7'h0, exp}, {7'h0, flag(sel)});
		if (flag(sel) !== exp)
			wrap_up();
	endtask : chk_flag

	task automatic wait_idle(input bit need_empty);
		int i;
		for (i = 0; i < 3000 && (cmd_ready !== 1'b1 || (need_empty && exp_q.size() != 0)); i++)
			@(negedge clk_sys);
		if (i == 3000)
		begin
			n_errors++;
			wrap_up();
		end
	endtask : wait_idle

	task automatic send(input logic [2:0] t, input logic [2:0] s, input logic sh, input logic [3:0] a,
		input logic [7:0] v);
		wait_idle(1'b0);
		cmd_type  = t;
		cmd_speed = s;
		cmd_short = sh;
		cmd_addr  = a;
		cmd_data  = v;
		cmd_valid = 1'b1;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
	endtask : send

	task automatic bus(input logic [2:0] t, input logic [2:0] s, input logic sh);
		logic [2:0] sp;
		sp = sh ? {s[2:1], 1'b0} : s;
		if (!newer_exp && sp > `PLIC_SPD_S400)
			exp_q.push_back('{2'h2, 8'h00, 8'h00});
		else
		begin
			exp_q.push_back('{2'h0, {5'h0, t}, {5'h0, sp}});
			exp_q.push_back('{2'h3, 8'h00, 8'h00});
		end
		send(t, s, sh, 4'h0, 8'h00);
	endtask : bus

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		mem[a] = v;
		send(PLIC_REQ_WRITE, 3'h0, 1'b0, a, v);
	endtask : wr

	task automatic rd(input logic [3:0] a);
		exp_q.push_back('{2'h1, {4'h0, a}, mem[a]});
		send(PLIC_REQ_READ, 3'h0, 1'b0, a, 8'h00);
	endtask : rd

	task automatic run_mode(input logic nw);
		int         s;
		logic [3:0] a;
		newer_exp                  = nw;
		interface_generation_strap = nw;
		rst_n                      = 1'b0;
		foreach (mem[i])
			mem[i] = 8'h00;
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		chk_flag("mode", 0, nw);
		chk_flag("power mode", 3, 1'b0);
		rd(4'h0);
		for (s = 0; s < 8; s++)
			bus(3'($urandom % 4), s[2:0], 1'b0);
		for (s = 0; s < 3; s++)
		begin
			a = 4'($urandom % 15);
			if (a == 4'h5)
				a = 4'hF;
			bus(3'($urandom % 4), {s[1:0], 1'b0}, 1'b1);
			wr(a, 8'($urandom));
			rd(a);
		end
		send(PLIC_REQ_RSV, 3'h0, 1'b0, 4'h0, 8'h00);
		wr(`PLIC_REG_FEAT, 8'h03);
		chk_flag("concat", 2, 1'b1);
		chk_flag("accel", 1, 1'b1);
		send(PLIC_REQ_ACC, 3'h0, 1'b0, 4'h0, 8'h00);
		chk_flag("accel off", 1, 1'b0);
		send(PLIC_REQ_ACC, 3'h0, 1'b0, 4'h0, 8'h01);
		chk_flag("accel on", 1, 1'b1);
		wr(`PLIC_REG_FEAT, 8'h00);
		chk_flag("concat off", 2, 1'b0);
		rd(`PLIC_REG_FEAT);
		wait_idle(1'b1);
	endtask : run_mode

	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	initial
	begin
		repeat (90000) @(posedge clk_sys);
		n_errors++;
		wrap_up();
	end

	initial
	begin
		rst_n                      = 1'b0;
		interface_generation_strap = 1'b1;
		cmd_valid                  = 1'b0;
		cmd_type                   = 3'h0;
		cmd_speed                  = 3'h0;
		cmd_short                  = 1'b0;
		cmd_addr                   = 4'h0;
		cmd_data                   = 8'h00;
		was_prefix                 = 1'b0;
		n_errors                   = 0;
		n_checks                   = 0;
		void'($urandom(88));
		@(negedge clk_sys);
		run_mode(1'b1);
		run_mode(1'b0);
		wrap_up();
	end
endmodule : phy_link_interface_mode_compat_test
